// *** rtl/flk_lock_status.sv ***
// Operation
// RL1: Every block comes out of power-up locked.
// RL2: Program and erase on a locked block are refused; reads still work.
// RL3: Lock setup 60h then 01h to a block sets its lock bit.
// RL4: Setup followed by read-config command loads the config register, no lock change.
// RL5: Lock changes and lock reads ignore the program supply level.
// RL6: Setup then D0h clears the addressed block's lock bit.
// RL7: Setup then 2Fh sets lock-down; locked-down unlock needs write-protect deasserted.
// RL8: Host issues lock-down before pulling write-protect low.
// RL9: Reset returns every block to plain locked, lock-down cleared.
// RL10: Identifier read gives lock bit on bit 0, lock-down on bit 1.
// RL11: Lock changes allowed in erase suspend, rejected in program suspend.
// RL12: Bad second cycle after setup sets status bits 4 and 5.
// RL13: Sequence error stays through erase resume until status is cleared.
// RL14: Locking an erase-suspended block acts at once; erase still finishes.
// RL15: After program, erase or lock sequences reads return status until new command.
// RL16: Status reads drive status on low byte, zeros on high byte.
// RL17: Async mode captures fresh status on first falling OE or CE.
// RL18: Burst mode refreshes status only on CE or ADV toggle, repeating the word.
// RL19: Async page non-array reads: only first word valid, rest undefined.
// RL20: Bit 7 ready, bit 6 erase suspend, bit 2 program suspend.
// RL21: Bits 5:4 encode success, program, erase, sequence error; error aborts.
// RL22: Bit 3 supply fault, bit 1 locked abort, bit 0 fast load busy.
// RL23: Status resets to 0x80; clear with 50h or reset, 15us settle.
// RL24: Device sets and clears bits 7,6,2; bits 5:3,1 only set until cleared.
// RL25: Volatile lock and lock-down bit per block; lock-down cleared only by reset.
`timescale 1ns/1ps
`default_nettype none
`include "flk_params.svh"

module flk_lock_status (
  // Clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_n_i,
  // Command writes and pins
  input  wire flk_pkg::flk_cmd_t      cmd_i,
  input  wire logic                   wp_n_i,
  // Program/erase engine
  input  wire flk_pkg::flk_core_t     core_i,
  input  wire flk_pkg::flk_op_t       op_i,
  output logic                        op_grant_o,
  output logic                        op_refuse_o,
  // Reads
  input  wire flk_pkg::flk_rd_t       rd_i,
  input  wire logic [15:0]            array_data_i,
  output logic [15:0]                 rd_data_o,
  output logic                        rd_valid_o,
  // Status view
  output logic [7:0]                  status_o,
  output logic                        clr_wait_o
);

  flk_pkg::flk_state_t q;
  flk_pkg::flk_state_t n;
  logic [7:0]          live_sr;
  logic                lock_op;
  logic                seq_err;

  always_comb begin
    n          = q;
    n.grant    = 1'b0;
    n.refuse   = 1'b0;
    n.rd_valid = 1'b0;
    lock_op    = 1'b0;
    seq_err    = 1'b0;
    live_sr    = 8'h00;
    if (q.clr_cnt != '0) begin
      n.clr_cnt = q.clr_cnt - `FLK_CLR_CNT_W'(1); // RL23
    end

    // Commands; lock state never looks at the supply level
    if (cmd_i.valid) begin // RL5
      if (q.setup_pend) begin
        n.setup_pend = 1'b0;
        n.mode       = flk_pkg::FLK_RD_STATUS; // RL15
        case (cmd_i.code)
          `FLK_CMD_LOCK, `FLK_CMD_UNLOCK, `FLK_CMD_LDOWN: begin
            lock_op = 1'b1;
            if (core_i.prog_susp) begin
              seq_err = 1'b1; // RL11
            end
          end
          `FLK_CMD_RCR_CFG: begin
            n.read_config_reg  = cmd_i.cfg; // RL4
            n.mode = q.mode;
          end
          default: begin
            seq_err = 1'b1; // RL12
          end
        endcase
        if (lock_op && !seq_err) begin
          // Erase-suspended block changes at once; the engine keeps its erase
          case (cmd_i.code) // RL14
            `FLK_CMD_LOCK: begin
              n.lock[cmd_i.blk] = 1'b1; // RL3
            end
            `FLK_CMD_UNLOCK: begin
              if (!q.ldown[cmd_i.blk] || wp_n_i) begin
                n.lock[cmd_i.blk] = 1'b0; // RL6 RL7
              end
            end
            default: begin
              n.lock[cmd_i.blk]  = 1'b1; // RL7
              n.ldown[cmd_i.blk] = 1'b1; // RL25
            end
          endcase
        end
      end else begin
        case (cmd_i.code)
          `FLK_CMD_LOCK_SETUP: begin
            n.setup_pend = 1'b1;
          end
          `FLK_CMD_CLR_SR: begin
            n.sticky  = 8'h00; // RL24
            n.clr_cnt = `FLK_CLR_CNT_W'(`FLK_CLR_WAIT_CYC); // RL23
          end
          `FLK_CMD_RD_SR: begin
            n.mode = flk_pkg::FLK_RD_STATUS;
          end
          `FLK_CMD_RD_ID: begin
            n.mode = flk_pkg::FLK_RD_IDENT;
          end
          `FLK_CMD_RD_ARRAY: begin
            n.mode = flk_pkg::FLK_RD_ARRAY;
          end
          `FLK_CMD_PROG, `FLK_CMD_PROG_ALT, `FLK_CMD_ERASE,
          `FLK_CMD_SUSPEND, `FLK_CMD_RESUME: begin
            n.mode = flk_pkg::FLK_RD_STATUS; // RL15
          end
          default: begin
            n.mode = q.mode;
          end
        endcase
      end
    end

    // Program/erase start checks against the registered lock bits
    if (op_i.valid) begin
      if (q.lock[op_i.blk]) begin
        n.refuse               = 1'b1; // RL2
        n.sticky[`FLK_SR_LOCKAB] = 1'b1; // RL22
        if (op_i.erase) begin
          n.sticky[`FLK_SR_ERR_HI] = 1'b1; // RL21
        end else begin
          n.sticky[`FLK_SR_ERR_LO] = 1'b1; // RL21
        end
      end else begin
        n.grant = 1'b1;
      end
    end

    // Sets come after the clear so an event in the clearing cycle survives
    if (seq_err) begin
      n.sticky[`FLK_SR_ERR_HI] = 1'b1; // RL12 RL13
      n.sticky[`FLK_SR_ERR_LO] = 1'b1;
    end
    if (core_i.prog_err) begin
      n.sticky[`FLK_SR_ERR_LO] = 1'b1; // RL21
    end
    if (core_i.erase_err) begin
      n.sticky[`FLK_SR_ERR_HI] = 1'b1; // RL21
    end
    if (core_i.vpp_low) begin
      n.sticky[`FLK_SR_VPP] = 1'b1; // RL22
    end

    n.clr_wait              = (n.clr_cnt != '0); // RL23
    live_sr                 = n.sticky;
    live_sr[`FLK_SR_RDY]    = !core_i.busy; // RL20
    live_sr[`FLK_SR_ESUSP]  = core_i.erase_susp; // RL20
    live_sr[`FLK_SR_PSUSP]  = core_i.prog_susp; // RL20
    live_sr[`FLK_SR_FAST_FACTORY_PROGRAM]   = core_i.fast_factory_program_load; // RL22
    n.sr_view               = live_sr;

    // Reads: first access of a cycle or burst captures fresh contents
    if (rd_i.valid) begin
      n.rd_valid = 1'b1;
      if (q.mode == flk_pkg::FLK_RD_ARRAY) begin
        n.rd_data = array_data_i;
      end else if (rd_i.first) begin // RL17 RL18
        if (q.mode == flk_pkg::FLK_RD_STATUS) begin
          n.rd_data = {8'h00, q.sr_view}; // RL16
        end else if (rd_i.off == `FLK_ID_LOCK_OFF) begin
          n.rd_data = {14'h0000, q.ldown[rd_i.blk], q.lock[rd_i.blk]}; // RL10
        end else if (rd_i.off == `FLK_ID_RCR_OFF) begin
          n.rd_data = q.read_config_reg;
        end else begin
          n.rd_data = 16'h0000;
        end
      end else if (q.read_config_reg[`FLK_RCR_ASYNC_BIT]) begin
        n.rd_data = 16'h0000; // RL19
      end else begin
        n.rd_data = q.rd_data; // RL18
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q.mode       <= flk_pkg::FLK_RD_ARRAY;
      q.setup_pend <= 1'b0;
      q.lock       <= '1; // RL1 RL9
      q.ldown      <= '0; // RL9 RL25
      q.sticky     <= 8'h00;
      q.sr_view    <= `FLK_SR_RST; // RL23
      q.read_config_reg        <= `FLK_RCR_RST;
      q.rd_data    <= 16'h0000;
      q.rd_valid   <= 1'b0;
      q.grant      <= 1'b0;
      q.refuse     <= 1'b0;
      q.clr_cnt    <= '0;
      q.clr_wait   <= 1'b0;
    end else begin
      q <= n;
    end
  end

  assign op_grant_o  = q.grant;
  assign op_refuse_o = q.refuse;
  assign rd_data_o   = q.rd_data;
  assign rd_valid_o  = q.rd_valid;
  assign status_o    = q.sr_view;
  assign clr_wait_o  = q.clr_wait;

  // Checking helpers
  logic seen_q;
  logic setup_hit;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  assign setup_hit = cmd_i.valid && q.setup_pend;

  reset_all_locked_a: assert property ( // RL1
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !seen_q |-> (&q.lock && q.ldown == '0 && status_o == `FLK_SR_RST))
    else $error("blocks not all plain locked after reset");

  locked_refuse_a: assert property ( // RL2
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    op_i.valid && q.lock[op_i.blk] |=> op_refuse_o && !op_grant_o
      && status_o[`FLK_SR_LOCKAB])
    else $error("operation on locked block not refused");

  lock_cmd_sets_a: assert property ( // RL3
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    setup_hit && cmd_i.code == `FLK_CMD_LOCK && !core_i.prog_susp
      |=> q.lock[$past(cmd_i.blk)] && q.mode == flk_pkg::FLK_RD_STATUS)
    else $error("lock sequence did not set lock bit");

  rcr_no_lock_a: assert property ( // RL4
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    setup_hit && cmd_i.code == `FLK_CMD_RCR_CFG
      |=> q.read_config_reg == $past(cmd_i.cfg) && q.lock == $past(q.lock))
    else $error("config load changed lock state");

  unlock_clears_a: assert property ( // RL6
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    setup_hit && cmd_i.code == `FLK_CMD_UNLOCK && !core_i.prog_susp
      && (wp_n_i || !q.ldown[cmd_i.blk]) |=> !q.lock[$past(cmd_i.blk)])
    else $error("unlock did not clear lock bit");

  ldown_hold_a: assert property ( // RL7
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    setup_hit && cmd_i.code == `FLK_CMD_UNLOCK && !wp_n_i && q.ldown[cmd_i.blk]
      |=> q.lock[$past(cmd_i.blk)] && q.ldown[$past(cmd_i.blk)])
    else $error("locked-down block unlocked under write protect");

  ident_bits_a: assert property ( // RL10
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    rd_i.valid && rd_i.first && q.mode == flk_pkg::FLK_RD_IDENT
      && rd_i.off == `FLK_ID_LOCK_OFF
      |=> rd_data_o == {14'h0000, $past(q.ldown[rd_i.blk]), $past(q.lock[rd_i.blk])})
    else $error("identifier lock bits wrong");

  psusp_reject_a: assert property ( // RL11
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    setup_hit && cmd_i.code == `FLK_CMD_LOCK && core_i.prog_susp
      |=> q.lock == $past(q.lock) && status_o[5:4] == 2'b11)
    else $error("lock change accepted in program suspend");

  seq_error_a: assert property ( // RL12
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    setup_hit && cmd_i.code != `FLK_CMD_LOCK && cmd_i.code != `FLK_CMD_UNLOCK
      && cmd_i.code != `FLK_CMD_LDOWN && cmd_i.code != `FLK_CMD_RCR_CFG
      |=> status_o[5:4] == 2'b11 && q.lock == $past(q.lock))
    else $error("command sequence error not flagged");

  sticky_keep_a: assert property ( // RL24
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    status_o[5:4] == 2'b11 && !(cmd_i.valid && !q.setup_pend
      && cmd_i.code == `FLK_CMD_CLR_SR) |=> status_o[5:4] == 2'b11)
    else $error("error bits dropped without clear");

  status_upper_a: assert property ( // RL16
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    rd_i.valid && rd_i.first && q.mode == flk_pkg::FLK_RD_STATUS
      |=> rd_data_o == {8'h00, $past(status_o)})
    else $error("status read word malformed");

  clr_settle_a: assert property ( // RL23
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    cmd_i.valid && !q.setup_pend && cmd_i.code == `FLK_CMD_CLR_SR
      |=> clr_wait_o [*8])
    else $error("settle window too short after clear");

  ready_bit_a: assert property ( // RL20
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    seen_q |-> status_o[`FLK_SR_RDY] == !$past(core_i.busy))
    else $error("ready bit does not follow engine");

  grant_free_a: assert property ( // RL2
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    op_i.valid && !q.lock[op_i.blk] |=> op_grant_o && !op_refuse_o)
    else $error("operation on unlocked block not granted");

  ldown_keep_a: assert property ( // RL25
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    seen_q |-> ($past(q.ldown) & ~q.ldown) == '0)
    else $error("lock-down bit cleared without reset");

  page_undef_a: assert property ( // RL19
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    rd_i.valid && !rd_i.first && q.mode != flk_pkg::FLK_RD_ARRAY
      && q.read_config_reg[`FLK_RCR_ASYNC_BIT] |=> rd_data_o == 16'h0000)
    else $error("later async page word not blanked");

  lock_down_c: cover property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    setup_hit && cmd_i.code == `FLK_CMD_LDOWN ##1 !wp_n_i);

  esusp_lock_c: cover property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    setup_hit && cmd_i.code == `FLK_CMD_LOCK && core_i.erase_susp);

  refuse_c: cover property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    op_refuse_o);

  rcr_load_c: cover property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    setup_hit && cmd_i.code == `FLK_CMD_RCR_CFG);

  clr_done_c: cover property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $fell(clr_wait_o));

endmodule // flk_lock_status

`default_nettype wire

// *** shared/flk_params.svh ***
`ifndef FLK_PARAMS_SVH
`define FLK_PARAMS_SVH

// Array geometry
`define FLK_NUM_BLK        256
`define FLK_BLK_AW         8

// Command codes
`define FLK_CMD_LOCK_SETUP 8'h60
`define FLK_CMD_LOCK       8'h01
`define FLK_CMD_UNLOCK     8'hd0
`define FLK_CMD_LDOWN      8'h2f
`define FLK_CMD_RCR_CFG    8'h03
`define FLK_CMD_CLR_SR     8'h50
`define FLK_CMD_RD_SR      8'h70
`define FLK_CMD_RD_ID      8'h90
`define FLK_CMD_RD_ARRAY   8'hff
`define FLK_CMD_PROG       8'h40
`define FLK_CMD_PROG_ALT   8'h10
`define FLK_CMD_ERASE      8'h20
`define FLK_CMD_SUSPEND    8'hb0
`define FLK_CMD_RESUME     8'hd0

// Status register fields
`define FLK_SR_RDY         7
`define FLK_SR_ESUSP       6
`define FLK_SR_ERR_HI      5
`define FLK_SR_ERR_LO      4
`define FLK_SR_VPP         3
`define FLK_SR_PSUSP       2
`define FLK_SR_LOCKAB      1
`define FLK_SR_FAST_FACTORY_PROGRAM        0
`define FLK_SR_RST         8'h80
`define FLK_SR_RST_WORD    16'h0080

// Identifier space and read configuration
`define FLK_ID_LOCK_OFF    8'h02
`define FLK_ID_RCR_OFF     8'h05
`define FLK_RCR_RST        16'h8000
`define FLK_RCR_ASYNC_BIT  15

// Settling time after clearing the status register
`define FLK_CLK_NS         4
`define FLK_CLR_WAIT_NS    15000
`define FLK_CLR_WAIT_CYC   ((`FLK_CLR_WAIT_NS + `FLK_CLK_NS - 1) / `FLK_CLK_NS)
`define FLK_CLR_CNT_W      12

`endif

// *** shared/flk_pkg.sv ***
`default_nettype none
`include "flk_params.svh"

package flk_pkg;

  typedef enum logic [1:0] {
    FLK_RD_ARRAY  = 2'b00,
    FLK_RD_STATUS = 2'b01,
    FLK_RD_IDENT  = 2'b10
  } flk_rd_mode_t;

  // Command write cycle
  typedef struct packed {
    logic                   valid;
    logic [7:0]             code;
    logic [`FLK_BLK_AW-1:0] blk;
    logic [15:0]            cfg;
  } flk_cmd_t;

  // Levels and pulses from the program/erase engine
  typedef struct packed {
    logic busy;
    logic erase_susp;
    logic prog_susp;
    logic vpp_low;
    logic fast_factory_program_load;
    logic prog_err;
    logic erase_err;
  } flk_core_t;

  // Program or erase start request
  typedef struct packed {
    logic                   valid;
    logic                   erase;
    logic [`FLK_BLK_AW-1:0] blk;
  } flk_op_t;

  // Read access
  typedef struct packed {
    logic                   valid;
    logic                   first;
    logic [7:0]             off;
    logic [`FLK_BLK_AW-1:0] blk;
  } flk_rd_t;

  typedef struct packed {
    flk_rd_mode_t             mode;
    logic                     setup_pend;
    logic [`FLK_NUM_BLK-1:0]  lock;
    logic [`FLK_NUM_BLK-1:0]  ldown;
    logic [7:0]               sticky;
    logic [7:0]               sr_view;
    logic [15:0]              read_config_reg;
    logic [15:0]              rd_data;
    logic                     rd_valid;
    logic                     grant;
    logic                     refuse;
    logic [`FLK_CLR_CNT_W-1:0] clr_cnt;
    logic                     clr_wait;
  } flk_state_t;

endpackage

`default_nettype wire

// *** tb/flk_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module flk_host_model (
  // Clock
  input  wire logic               sys_clk_i,
  // Bus cycles toward the device
  output var flk_pkg::flk_cmd_t   cmd_o,
  output var flk_pkg::flk_rd_t    rd_o,
  output var flk_pkg::flk_op_t    op_o,
  // Answers from the device
  input  wire logic [15:0]        rd_data_i,
  input  wire logic               rd_valid_i,
  input  wire logic               grant_i,
  input  wire logic               refuse_i
);
  initial begin
    cmd_o = '0;
    rd_o  = '0;
    op_o  = '0;
  end

  // Released lines show the inverse so a stale value never looks valid
  task automatic wr(input logic [7:0] code, input logic [7:0] blk = 8'h00,
                    input logic [15:0] cfg = 16'h0000);
    @(negedge sys_clk_i);
    cmd_o <= '{1'b1, code, blk, cfg};
    @(negedge sys_clk_i);
    cmd_o <= '{1'b0, ~code, ~blk, ~cfg};
  endtask

  task automatic rd(input logic [7:0] off, input logic [7:0] blk, input logic first,
                    output logic [15:0] data, output logic vld);
    @(negedge sys_clk_i);
    rd_o <= '{1'b1, first, off, blk};
    @(negedge sys_clk_i);
    rd_o <= '{1'b0, ~first, ~off, ~blk};
    data = rd_data_i;
    vld  = rd_valid_i;
  endtask

  task automatic op(input logic erase, input logic [7:0] blk, output logic [1:0] gr);
    @(negedge sys_clk_i);
    op_o <= '{1'b1, erase, blk};
    @(negedge sys_clk_i);
    op_o <= '{1'b0, ~erase, ~blk};
    gr = {grant_i, refuse_i};
  endtask
endmodule // flk_host_model

`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flk_params.svh"

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_total++; \
  $display("ERROR t=%0t got %h exp %h", $time, got, exp); end end

module tb_top;
  logic               sys_clk_i;
  logic               rst_n_i;
  logic               wp_n_i;
  logic [15:0]        array_data_i;
  flk_pkg::flk_core_t core_i;
  flk_pkg::flk_cmd_t  cmd;
  flk_pkg::flk_rd_t   rd;
  flk_pkg::flk_op_t   op;
  logic               grant;
  logic               refuse;
  logic [15:0]        rd_data;
  logic               rd_valid;
  logic [7:0]         status;
  logic               clr_wait;
  logic [15:0]        d;
  logic               v;
  logic [1:0]         gr;
  int                 err_total = 0;
  int                 checks = 0;
  logic [7:0]         mc [5] = '{8'h40, 8'h10, 8'h20, 8'hb0, 8'hd0};

  flk_lock_status flk_lock_status_inst (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd), .wp_n_i(wp_n_i),
    .core_i(core_i), .op_i(op), .op_grant_o(grant), .op_refuse_o(refuse),
    .rd_i(rd), .array_data_i(array_data_i), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .status_o(status), .clr_wait_o(clr_wait)
  );

  flk_host_model flk_host_model_inst (
    .sys_clk_i(sys_clk_i), .cmd_o(cmd), .rd_o(rd), .op_o(op), .rd_data_i(rd_data),
    .rd_valid_i(rd_valid), .grant_i(grant), .refuse_i(refuse)
  );

  task automatic give_verdict;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic w(input logic [7:0] code, input logic [7:0] blk = 8'h00,
                   input logic [15:0] cfg = 16'h0000);
    flk_host_model_inst.wr(code, blk, cfg);
  endtask

  task automatic r(input logic [7:0] off, input logic [7:0] blk, input logic first);
    flk_host_model_inst.rd(off, blk, first, d, v);
  endtask

  // Clear status, then hold off for the settle time before the next command
  task automatic clr;
    int n;
    w(8'h50);
    `CHK(clr_wait, 1'b1)
    n = 0;
    while (clr_wait && n < 4000) begin
      n++;
      @(negedge sys_clk_i);
    end
    `CHK(n, `FLK_CLR_WAIT_CYC)
  endtask

  // Lock state of one block through the identifier space
  task automatic lk(input logic [7:0] blk, input logic [1:0] exp);
    w(8'h90);
    r(8'h02, blk, 1'b1);
    `CHK({v, d}, {1'b1, 14'h0000, exp})
  endtask

  // Status word as seen on a first read, upper byte zero
  task automatic st(input logic [7:0] exp);
    w(8'h70);
    r(8'h00, 8'h00, 1'b1);
    `CHK({v, d}, {1'b1, 8'h00, exp})
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  // Bounds the whole run; a hang is counted as a mismatch
  initial begin
    repeat (40000) @(posedge sys_clk_i);
    err_total++;
    give_verdict();
  end

  initial begin
    rst_n_i = 1'b0;
    wp_n_i = 1'b1;
    array_data_i = 16'h5a3c;
    core_i = '0;
    repeat (6) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    @(negedge sys_clk_i);
    `CHK(status, 8'h80)
    lk(8'h05, 2'b01);
    flk_host_model_inst.op(1'b0, 8'h05, gr);
    `CHK(gr, 2'b01)
    `CHK(status, 8'h92)
    clr();
    st(8'h80);
    w(8'h60, 8'h05);
    w(8'hd0, 8'h05);
    r(8'h00, 8'h00, 1'b1);
    `CHK({v, d}, 17'h10080)
    flk_host_model_inst.op(1'b1, 8'h05, gr);
    `CHK(gr, 2'b10)
    lk(8'h05, 2'b00);
    // Lock-down taken with the supply low and the engine busy
    core_i = '{busy: 1'b1, vpp_low: 1'b1, fast_factory_program_load: 1'b1, default: 1'b0};
    w(8'h60, 8'h05);
    w(8'h2f, 8'h05);
    lk(8'h05, 2'b11);
    `CHK(status, 8'h09)
    core_i = '0;
    clr();
    st(8'h80);
    wp_n_i = 1'b0;
    w(8'h60, 8'h05);
    w(8'hd0, 8'h05);
    lk(8'h05, 2'b11);
    wp_n_i = 1'b1;
    w(8'h60, 8'h05);
    w(8'hd0, 8'h05);
    lk(8'h05, 2'b10);
    w(8'h60, 8'h05);
    w(8'hff, 8'h05);
    st(8'hb0);
    clr();
    core_i.prog_susp = 1'b1;
    w(8'h60, 8'h05);
    w(8'h01, 8'h05);
    st(8'hb4);
    lk(8'h05, 2'b10);
    core_i.prog_susp = 1'b0;
    clr();
    core_i.erase_susp = 1'b1;
    w(8'h60, 8'h05);
    w(8'h01, 8'h05);
    lk(8'h05, 2'b11);
    w(8'h60, 8'h06);
    w(8'h70, 8'h06);
    core_i.erase_susp = 1'b0;
    st(8'hb0);
    clr();
    // Burst config: later words repeat the first
    w(8'h60, 8'h00, 16'h1234);
    w(8'h03, 8'h00, 16'h1234);
    w(8'h90);
    r(8'h05, 8'h00, 1'b1);
    `CHK(d, 16'h1234)
    r(8'h05, 8'h00, 1'b0);
    `CHK(d, 16'h1234)
    lk(8'h05, 2'b11);
    w(8'h60, 8'h00, 16'h8000);
    w(8'h03, 8'h00, 16'h8000);
    w(8'h90);
    r(8'h05, 8'h00, 1'b1);
    `CHK(d, 16'h8000)
    r(8'h05, 8'h00, 1'b0);
    `CHK(d, 16'h0000)
    w(8'hff);
    r(8'h00, 8'h03, 1'b1);
    `CHK(d, 16'h5a3c)
    // Every program, erase, suspend and resume command turns reads back to status
    for (int i = 0; i < 5; i++) begin
      w(8'hff);
      w(mc[i]);
      r(8'h00, 8'h03, 1'b1);
      `CHK({v, d}, 17'h10080)
    end
    // Reset in mid-run drops lock-down
    @(negedge sys_clk_i);
    rst_n_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    lk(8'h05, 2'b01);
    give_verdict();
  end
endmodule // tb_top

`default_nettype wire
